// file: rtl/fault_code_map.svh
`ifndef FAULT_CODE_MAP_SVH
`define FAULT_CODE_MAP_SVH

// ----------------------------------------------------------------------------
// Code values
// ----------------------------------------------------------------------------
`define FC_NONE              16'h0000
`define FC_USER_CKSUM        16'h0001
`define FC_COMPILED_CKSUM    16'h0002
`define FC_WATCHDOG          16'h0003
`define FC_EEPROM_BASE       16'h0004
`define FC_CART_BASE         16'h000a
`define FC_SOFTWARE          16'h0010
`define FC_CMP_INDIRECT      16'h0011
`define FC_CMP_ILLEGAL       16'h0012
`define FC_CART_BLANK        16'h0013
`define RC_NONE              16'h0000
`define INFO_NONE            16'h0000
`define OUTS_OFF             8'h00
`define RC_RANGE_ADDR        16'h0091
`define RC_COUNT_FIELD       16'h0092
`define RC_NVM_RANGE         16'h0094
`define CC_NONE              16'h0000
`define CC_LOW               16'h0080
`define CC_HIGH              16'h0096
`define CC_RSV_A             16'h0084
`define CC_RSV_B             16'h008a
`define CC_RSV_C             16'h008b
`define CODE_W               16
`define INFO_W               16

`endif

// file: rtl/fault_code_pkg.sv
package fault_code_pkg;

    // Fatal sources, one request bit each; lowest index wins
    typedef struct packed {
        logic       cart_blank;
        logic       cmp_illegal;
        logic       cmp_indirect;
        logic       software;
        logic [5:0] cart;
        logic [5:0] eeprom;
        logic       watchdog;
        logic       compiled_cksum;
        logic       user_cksum;
    } fatal_src_t;

    // Run-time event: valid, the code in the low byte and a 16-bit info word
    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [15:0] info;
    } rt_event_t;

    // Compile-rule event carried by the download engine
    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
    } cc_event_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT
    } cpu_mode_t;

endpackage

// file: rtl/controller_fault_code_reporter.sv
`timescale 1ns/10ps
`include "fault_code_map.svh"

// Summary of operation
// - Any fatal error halts program execution
// - Fatal error lights fault and halt indicators
// - Fatal error forces all process outputs off
// - Hold safe state until corrected; keep answering
// - Fatal code readable, zero without fault
// - Codes 0001/0002 for program checksum failures
// - Scan watchdog expiry is fatal code 0003
// - EEPROM faults give codes 0004 to 0009
// - Cartridge faults give codes 000A to 000F
// - Blank or foreign cartridge gives code 0013
// - Codes 0010, 0011, 0012 software and compare
// - Program errors set run-time code, no halt
// - Run-time codes 0001, 0002, 0003, 000A
// - Run-time codes 0004, 0005, 0008
// - Overlapping transmit/receive gives run-time 0009
// - Run-time 0006 indirect, 0007 time write
// - Codes 0091/0092/0094 carry address or count
// - Compile-rule break aborts download, sets code
// - Compile codes 0080..0096, reserved never generated
// - Run-time problem also sets program flag
module controller_fault_code_reporter (
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     sys_rst_i,
    // Fatal error sources and their clearing
    input  wire fault_code_pkg::fatal_src_t fatal_src_i,
    input  wire logic                     fault_corrected_i,
    // Run-time and compile-rule events
    input  wire fault_code_pkg::rt_event_t rt_event_i,
    input  wire fault_code_pkg::cc_event_t cc_event_i,
    input  wire logic                     rt_flag_clear_i,
    input  wire logic                     cc_clear_i,
    // Process outputs from the program
    input  wire logic [7:0]               proc_out_i,
    // Status read strobe from the programming device
    input  wire logic                     status_rd_i,
    // Controller state
    output logic                          prog_run_o,
    output logic                          fault_led_o,
    output logic                          halt_led_o,
    output logic [7:0]                    proc_out_o,
    output logic                          download_abort_o,
    output logic                          runtime_problem_flag_o,
    // Code registers and read answer
    output logic [15:0]                   fatal_code_o,
    output logic [15:0]                   rt_code_o,
    output logic [15:0]                   rt_info_o,
    output logic [15:0]                   cc_code_o,
    output logic                          status_ack_o
);

    // ------------------------------------------------------------------------
    // Fatal code selection
    // ------------------------------------------------------------------------
    logic [`CODE_W-1:0]       fatal_sel;
    logic                     fatal_any;

    // Lowest index wins, so the most basic failure is the one reported
    always_comb begin
        fatal_sel = `FC_NONE;
        fatal_any = 1'b1;
        if (fatal_src_i.user_cksum) begin
            fatal_sel = `FC_USER_CKSUM;
        end else if (fatal_src_i.compiled_cksum) begin
            fatal_sel = `FC_COMPILED_CKSUM;
        end else if (fatal_src_i.watchdog) begin
            fatal_sel = `FC_WATCHDOG;
        end else if (|fatal_src_i.eeprom) begin
            fatal_sel = `FC_EEPROM_BASE;
            for (int i = 5; i >= 0; i--) begin
                if (fatal_src_i.eeprom[i]) begin
                    fatal_sel = `FC_EEPROM_BASE + 16'(i);
                end
            end
        end else if (|fatal_src_i.cart) begin
            fatal_sel = `FC_CART_BASE;
            for (int i = 5; i >= 0; i--) begin
                if (fatal_src_i.cart[i]) begin
                    fatal_sel = `FC_CART_BASE + 16'(i);
                end
            end
        end else if (fatal_src_i.software) begin
            fatal_sel = `FC_SOFTWARE;
        end else if (fatal_src_i.cmp_indirect) begin
            fatal_sel = `FC_CMP_INDIRECT;
        end else if (fatal_src_i.cmp_illegal) begin
            fatal_sel = `FC_CMP_ILLEGAL;
        end else if (fatal_src_i.cart_blank) begin
            fatal_sel = `FC_CART_BLANK;
        end else begin
            fatal_any = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Halt state machine
    // ------------------------------------------------------------------------
    fault_code_pkg::cpu_mode_t mode_ff;
    fault_code_pkg::cpu_mode_t nxt_mode;
    logic [`CODE_W-1:0]       fatal_code_ff;
    logic [`CODE_W-1:0]       nxt_fatal_code;

    always_comb begin
        nxt_mode       = mode_ff;
        nxt_fatal_code = fatal_code_ff;
        case (mode_ff)
            fault_code_pkg::ST_RUN: begin
                if (fatal_any) begin
                    nxt_mode       = fault_code_pkg::ST_HALT;
                    nxt_fatal_code = fatal_sel;
                end
            end
            fault_code_pkg::ST_HALT: begin
                // Leaving needs both the repair and no live source, so a
                // still-present fault cannot be cleared by software alone
                if (fault_corrected_i && !fatal_any) begin
                    nxt_mode       = fault_code_pkg::ST_RUN;
                    nxt_fatal_code = `FC_NONE;
                end
            end
            default: begin
                nxt_mode       = fault_code_pkg::ST_HALT;
                nxt_fatal_code = `FC_SOFTWARE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mode_ff       <= fault_code_pkg::ST_RUN;
            fatal_code_ff <= `FC_NONE;
        end else begin
            mode_ff       <= nxt_mode;
            fatal_code_ff <= nxt_fatal_code;
        end
    end

    // ------------------------------------------------------------------------
    // Run-time and compile-rule codes
    // ------------------------------------------------------------------------
    logic [`CODE_W-1:0]       rt_code_ff;
    logic [`CODE_W-1:0]       nxt_rt_code;
    logic [`INFO_W-1:0]       rt_info_ff;
    logic [`INFO_W-1:0]       nxt_rt_info;
    logic                     rt_flag_ff;
    logic                     nxt_rt_flag;
    logic [`CODE_W-1:0]       cc_code_ff;
    logic [`CODE_W-1:0]       nxt_cc_code;
    logic                     abort_ff;
    logic                     nxt_abort;
    logic [`CODE_W-1:0]       cc_wide;
    logic                     cc_legal;
    logic [`CODE_W-1:0]       rt_wide;
    logic                     rt_has_info;

    always_comb begin
        cc_wide     = {8'h00, cc_event_i.code};
        rt_wide     = {8'h00, rt_event_i.code};
        cc_legal    = (cc_wide >= `CC_LOW) && (cc_wide <= `CC_HIGH) &&
                      (cc_wide != `CC_RSV_A) && (cc_wide != `CC_RSV_B) &&
                      (cc_wide != `CC_RSV_C);
        rt_has_info = (rt_wide == `RC_RANGE_ADDR) || (rt_wide == `RC_COUNT_FIELD) ||
                      (rt_wide == `RC_NVM_RANGE);
        nxt_rt_code = rt_code_ff;
        nxt_rt_info = rt_info_ff;
        nxt_rt_flag = rt_flag_ff;
        nxt_cc_code = cc_code_ff;
        nxt_abort   = 1'b0;
        if (rt_flag_clear_i) begin
            nxt_rt_flag = 1'b0;
            nxt_rt_code = `RC_NONE;
            nxt_rt_info = `INFO_NONE;
        end
        // Set wins over a clear in the same cycle
        if (rt_event_i.valid && rt_wide != `RC_NONE && mode_ff == fault_code_pkg::ST_RUN) begin
            nxt_rt_code = rt_wide;
            nxt_rt_info = rt_has_info ? rt_event_i.info : `INFO_NONE;
            nxt_rt_flag = 1'b1;
        end
        if (cc_clear_i) begin
            nxt_cc_code = `CC_NONE;
        end
        if (cc_event_i.valid && cc_legal) begin
            nxt_cc_code = cc_wide;
            nxt_abort   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rt_code_ff <= `RC_NONE;
            rt_info_ff <= `INFO_NONE;
            rt_flag_ff <= 1'b0;
            cc_code_ff <= `CC_NONE;
            abort_ff   <= 1'b0;
        end else begin
            rt_code_ff <= nxt_rt_code;
            rt_info_ff <= nxt_rt_info;
            rt_flag_ff <= nxt_rt_flag;
            cc_code_ff <= nxt_cc_code;
            abort_ff   <= nxt_abort;
        end
    end

    // ------------------------------------------------------------------------
    // Indicators, outputs and read answer
    // ------------------------------------------------------------------------
    logic                     halt_now;
    // Run state gets its own flop so the pin never comes from a compare
    logic                     run_ff;
    logic [7:0]               out_ff;
    logic [7:0]               nxt_out;
    logic                     led_ff;
    logic                     ack_ff;

    // Outputs go off in the same edge that enters halt, not one scan later
    always_comb begin
        halt_now = (nxt_mode == fault_code_pkg::ST_HALT);
        nxt_out  = halt_now ? `OUTS_OFF : proc_out_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            run_ff <= 1'b1;
            out_ff <= `OUTS_OFF;
            led_ff <= 1'b0;
            ack_ff <= 1'b0;
        end else begin
            run_ff <= !halt_now;
            out_ff <= nxt_out;
            led_ff <= halt_now;
            ack_ff <= status_rd_i;
        end
    end

    assign prog_run_o             = run_ff;
    assign fault_led_o            = led_ff;
    assign halt_led_o             = led_ff;
    assign proc_out_o             = out_ff;
    assign download_abort_o       = abort_ff;
    assign runtime_problem_flag_o = rt_flag_ff;
    assign fatal_code_o           = fatal_code_ff;
    assign rt_code_o              = rt_code_ff;
    assign rt_info_o              = rt_info_ff;
    assign cc_code_o              = cc_code_ff;
    assign status_ack_o           = ack_ff;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence fatal_seen_s;
        prog_run_o && fatal_any;
    endsequence

    sequence safe_state_s;
        !prog_run_o && fault_led_o && halt_led_o && proc_out_o == 8'h00;
    endsequence

    AST_HALT_ON_FATAL: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        fatal_seen_s |=> safe_state_s) else $error("fatal error did not halt");
    AST_LEDS_TOGETHER: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        fault_led_o == !prog_run_o && halt_led_o == fault_led_o) else $error("indicators wrong");
    AST_OUTPUTS_OFF: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !prog_run_o |-> proc_out_o == 8'h00) else $error("outputs on while halted");
    AST_HOLD_HALT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!prog_run_o && !fault_corrected_i) |=> !prog_run_o) else $error("halt left uncorrected");
    AST_ACK: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        status_rd_i |=> status_ack_o) else $error("status read unanswered");
    AST_ZERO_IN_RUN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        prog_run_o |-> fatal_code_o == `FC_NONE) else $error("fatal code nonzero in run");
    AST_WATCHDOG: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (prog_run_o && fatal_src_i.watchdog && !fatal_src_i.user_cksum && !fatal_src_i.compiled_cksum)
        |=> fatal_code_o == `FC_WATCHDOG) else $error("watchdog code wrong");
    AST_RT_NO_HALT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (rt_event_i.valid && prog_run_o && !fatal_any) |=> prog_run_o) else $error("run-time error halted");
    AST_RT_FLAG: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (rt_event_i.valid && rt_event_i.code != 8'h00 && prog_run_o)
        |=> runtime_problem_flag_o && rt_code_o == $past(rt_wide)) else $error("run-time flag not set");
    AST_CC_RESERVED: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        cc_code_o != `CC_RSV_A && cc_code_o != `CC_RSV_B && cc_code_o != `CC_RSV_C)
        else $error("reserved compile code");
    AST_CC_ABORT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        download_abort_o |-> cc_code_o >= `CC_LOW && cc_code_o <= `CC_HIGH) else $error("abort without code");
    // A later source must not overwrite the code that caused the halt
    AST_CODE_FROZEN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!prog_run_o && !fault_corrected_i) |=> $stable(fatal_code_o))
        else $error("fatal code changed while halted");
    AST_CODE_IN_HALT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !prog_run_o |-> fatal_code_o != `FC_NONE) else $error("halted without fatal code");
    AST_CC_TAKEN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cc_event_i.valid && cc_legal) |=> download_abort_o && cc_code_o == $past(cc_wide))
        else $error("compile code not taken");
    AST_RT_INFO_ZERO: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (rt_event_i.valid && rt_event_i.code != 8'h00 && prog_run_o && !rt_has_info)
        |=> rt_info_o == `INFO_NONE) else $error("info kept for code without info");
    AST_RT_CLEAR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (rt_flag_clear_i && !rt_event_i.valid) |=> !runtime_problem_flag_o) else $error("run-time flag not cleared");

endmodule

// file: verification/status_reader.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Programming device that interrogates the error state
// ----------------------------------------------------------------------------
module status_reader (
    // Clock
    input  wire logic        sys_clk_i,
    // Answer from the controller
    input  wire logic        status_ack_i,
    input  wire logic [15:0] fatal_code_i,
    // Interrogation strobe
    output logic             status_rd_o
);
    initial status_rd_o = 1'b0;

    // One-cycle strobe, then count acknowledges over three cycles so that a
    // missing or doubled answer both show up as a wrong count
    task automatic interrogate(output int acks, output logic [15:0] code);
        acks = 0;
        code = 16'hffff;
        @(negedge sys_clk_i);
        status_rd_o = 1'b1;
        repeat (3) begin
            @(negedge sys_clk_i);
            status_rd_o = 1'b0;
            if (status_ack_i === 1'b1) begin
                acks++;
                code = fatal_code_i;
            end
        end
    endtask
endmodule

// file: verification/controller_fault_code_reporter_bench.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Bench for the fault code reporter
// ----------------------------------------------------------------------------
module controller_fault_code_reporter_bench;
    logic                       sys_clk_i = 1'b0;
    logic                       sys_rst_i = 1'b1;
    fault_code_pkg::fatal_src_t fsrc      = '0;
    fault_code_pkg::rt_event_t  rte       = '0;
    fault_code_pkg::cc_event_t  cce       = '0;
    logic                       fcor      = 1'b0;
    logic                       rclr      = 1'b0;
    logic                       cclr      = 1'b0;
    logic [7:0]                 pin       = 8'h00;
    logic                       rd;
    logic                       run, fled, hled, abrt, rflag, ack;
    logic [7:0]                 pout;
    logic [15:0]                fcode, rcode, rinfo, ccode;
    int                         errors          = 0;
    int                         samples_checked = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    controller_fault_code_reporter controller_fault_code_reporter_i (
        .sys_clk_i              (sys_clk_i),
        .sys_rst_i              (sys_rst_i),
        .fatal_src_i            (fsrc),
        .fault_corrected_i      (fcor),
        .rt_event_i             (rte),
        .cc_event_i             (cce),
        .rt_flag_clear_i        (rclr),
        .cc_clear_i             (cclr),
        .proc_out_i             (pin),
        .status_rd_i            (rd),
        .prog_run_o             (run),
        .fault_led_o            (fled),
        .halt_led_o             (hled),
        .proc_out_o             (pout),
        .download_abort_o       (abrt),
        .runtime_problem_flag_o (rflag),
        .fatal_code_o           (fcode),
        .rt_code_o              (rcode),
        .rt_info_o              (rinfo),
        .cc_code_o              (ccode),
        .status_ack_o           (ack)
    );

    status_reader status_reader_i (
        .sys_clk_i    (sys_clk_i),
        .status_ack_i (ack),
        .fatal_code_i (fcode),
        .status_rd_o  (rd)
    );

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic test_reset;
        chk("mode_leds", 16'h0004, {13'h0, run, fled, hled});
        chk("fatal_code", 16'h0000, fcode);
        chk("rt_code", 16'h0000, rcode);
        chk("cc_code", 16'h0000, ccode);
        chk("rt_flag", 16'h0000, {15'h0, rflag});
        $display("test_reset done");
    endtask

    // Each source alone, with cart_blank also live to prove lowest index wins
    task automatic test_fatal;
        int          acks;
        logic [15:0] code;
        for (int i = 0; i < $bits(fault_code_pkg::fatal_src_t); i++) begin
            pin = 8'ha5;
            fsrc = '0;
            fsrc[i] = 1'b1;
            fsrc[18] = 1'b1;
            step(2);
            chk("fatal_code", 16'(i + 1), fcode);
            chk("mode_leds", 16'h0003, {13'h0, run, fled, hled});
            chk("outputs", 16'h0000, {8'h0, pout});
            fsrc[0] = 1'b1;
            fcor = 1'b1;
            step(2);
            chk("held_code", 16'(i + 1), fcode);
            chk("held_mode", 16'h0003, {13'h0, run, fled, hled});
            status_reader_i.interrogate(acks, code);
            chk("status_acks", 16'h0001, 16'(acks));
            chk("status_code", 16'(i + 1), code);
            fsrc = '0;
            step(2);
            fcor = 1'b0;
            chk("cleared_code", 16'h0000, fcode);
            chk("run_mode", 16'h0004, {13'h0, run, fled, hled});
            chk("outputs_run", 16'h00a5, {8'h0, pout});
        end
        $display("test_fatal done");
    endtask

    task automatic test_runtime;
        logic [7:0]  codes [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                    8'h08, 8'h09, 8'h0a, 8'h91, 8'h92, 8'h94, 8'h06};
        logic [15:0] info;
        for (int k = 0; k < 14; k++) begin
            info = 16'h1230 + 16'(k);
            rte = '{1'b1, codes[k], info};
            step(1);
            rte = '0;
            step(1);
            chk("rt_code", {8'h00, codes[k]}, rcode);
            chk("rt_info", codes[k] >= 8'h91 ? info : 16'h0000, rinfo);
            chk("rt_flag", 16'h0001, {15'h0, rflag});
            chk("still_run", 16'h0001, {15'h0, run});
            rclr = 1'b1;
            step(1);
            rclr = 1'b0;
            step(1);
            chk("rt_cleared", 16'h0000, rcode);
            chk("rt_flag_cleared", 16'h0000, {15'h0, rflag});
            chk("rt_info_cleared", 16'h0000, rinfo);
        end
        $display("test_runtime done");
    endtask

    // Sweep just past both ends of the compile range
    task automatic test_compile;
        int   cnt;
        logic ok;
        for (int c = 'h7f; c <= 'h97; c++) begin
            ok = c >= 'h80 && c <= 'h96 && c != 'h84 && c != 'h8a && c != 'h8b;
            cce = '{1'b1, 8'(c)};
            step(1);
            cnt = int'(abrt);
            cce = '0;
            repeat (2) begin
                step(1);
                cnt += int'(abrt);
            end
            chk("abort_pulses", 16'(ok), 16'(cnt));
            chk("cc_code", ok ? 16'(c) : 16'h0000, ccode);
            cclr = 1'b1;
            step(1);
            cclr = 1'b0;
            step(1);
        end
        chk("cc_cleared", 16'h0000, ccode);
        $display("test_compile done");
    endtask

    // Set beats clear, run-time events while halted are dropped, reset leaves halt
    task automatic test_edges;
        rte  = '{1'b1, 8'h05, 16'h0000};
        rclr = 1'b1;
        cce  = '{1'b1, 8'h81};
        cclr = 1'b1;
        step(1);
        rte  = '0;
        rclr = 1'b0;
        cce  = '0;
        cclr = 1'b0;
        chk("rt_set_wins", 16'h0005, rcode);
        chk("cc_set_wins", 16'h0081, ccode);
        rclr = 1'b1;
        cclr = 1'b1;
        step(1);
        rclr = 1'b0;
        cclr = 1'b0;
        fsrc.watchdog = 1'b1;
        step(2);
        chk("wd_code", 16'h0003, fcode);
        rte = '{1'b1, 8'h06, 16'h0000};
        step(1);
        rte = '0;
        step(1);
        chk("rt_dropped", 16'h0000, rcode);
        chk("flag_dropped", 16'h0000, {15'h0, rflag});
        chk("still_halted", 16'h0003, {13'h0, run, fled, hled});
        fsrc = '0;
        sys_rst_i = 1'b1;
        step(2);
        sys_rst_i = 1'b0;
        step(1);
        chk("reset_mode", 16'h0004, {13'h0, run, fled, hled});
        chk("reset_code", 16'h0000, fcode);
        $display("test_edges done");
    endtask

    initial begin
        #200000;
        errors++;
        $display("[ERR] run_end expected finish seen timeout");
        print_verdict();
    end

    initial begin
        step(20);
        sys_rst_i = 1'b0;
        step(1);
        test_reset();
        test_fatal();
        test_runtime();
        test_compile();
        test_edges();
        print_verdict();
    end
endmodule
